// ===== logic/swt_defs.svh
`ifndef SWT_DEFS_SVH
`define SWT_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the configuration path)
// ----------------------------------------------------------------
`define SWT_OFS_TEST_B 8'h6C
`define SWT_OFS_OVERRIDE 8'h70
`define SWT_OFS_MODE 8'h74

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SWT_RST_TEST_B 32'h04000800
`define SWT_RST_OVERRIDE 32'h00000000
`define SWT_RST_MODE 32'h00000002

// ----------------------------------------------------------------
// Writable bit masks; all other bits read zero, except override bit 31, which reads the VGA flag
// ----------------------------------------------------------------
`define SWT_WMASK_TEST_B 32'hFFFFFFFF
`define SWT_WMASK_OVERRIDE 32'h7FFF1FFF
`define SWT_WMASK_MODE 32'h0000007F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWT_REPLAY_MSB 11
`define SWT_REPLAY_LSB 0
`define SWT_REPLAY_EN 12
`define SWT_ACK_MSB 29
`define SWT_ACK_LSB 16
`define SWT_ACK_EN 30
`define SWT_VGA_BIT 31
`define SWT_MODE_STORE_FWD 0
`define SWT_MODE_CT_MSB 2
`define SWT_MODE_CT_LSB 1
`define SWT_MODE_ARB_STICKY 3
`define SWT_MODE_CREDIT_ALL 4
`define SWT_MODE_EGRESS_ORD 5
`define SWT_MODE_TAG_ORD 6

// ----------------------------------------------------------------
// Widths and small constants
// ----------------------------------------------------------------
`define SWT_NPORTS 4
`define SWT_LEN_W 12
`define SWT_ZERO32 32'h00000000
`define SWT_ALL_BE 4'hF

`endif

// ===== logic/swt_pkg.sv
package swt_pkg;
  // Cut-through threshold codes, in field order
  typedef enum logic [1:0] {
    SWT_CT_MID,
    SWT_CT_AHEAD1,
    SWT_CT_AHEAD2,
    SWT_CT_AHEAD3
  } swt_ct_code_t;

  typedef logic [31:0] swt_word_t;
  typedef logic [11:0] swt_len_t;
endpackage

// ===== logic/swt_cut_thresh.sv
`timescale 1ns/10ps
`include "swt_defs.svh"

module swt_cut_thresh
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic i_start,
  input wire logic [11:0] i_len,
  input wire logic i_slow_to_fast,
  input wire logic i_store_fwd,
  input wire logic [1:0] i_code,
  output logic [11:0] o_fwd_start
);
  // ----------------------------------------------------------------
  // Forwarding start point
  // ----------------------------------------------------------------
  wire logic [11:0] mid;
  wire logic [11:0] ahead;
  wire logic [11:0] cut_point;
  wire logic [11:0] next_start;

  assign mid = i_len >> 1;
  // Threshold only moves for slow-to-fast forwarding
  // RL7 - slow to fast
  assign ahead = i_slow_to_fast ? {10'h000, i_code} : 12'h000;
  // RL8 - ahead of midpoint, saturating at zero
  assign cut_point = (mid > ahead) ? mid - ahead : 12'h000;
  // Store-forward waits for the whole packet
  // RL6 - full packet first
  assign next_start = i_store_fwd ? i_len : cut_point;

  // Captured once per packet start
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      o_fwd_start <= 12'h000;
    else if (i_start)
      o_fwd_start <= next_start;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_CT_AHEAD3: assert property ( // RL8
    i_start && !i_store_fwd && i_slow_to_fast && i_code == 2'h3
      && (i_len >> 1) > 12'h003
    |=> o_fwd_start == ($past(i_len) >> 1) - 12'h003)
    else $error("cut-through start not three ahead of midpoint");

  AST_CT_SAME_SPEED: assert property ( // RL7
    i_start && !i_store_fwd && !i_slow_to_fast
    |=> o_fwd_start == ($past(i_len) >> 1))
    else $error("threshold applied without speed change");

  AST_STORE_FWD: assert property ( // RL6
    i_start && i_store_fwd |=> o_fwd_start == $past(i_len))
    else $error("store-forward started before full packet");
endmodule // swt_cut_thresh

// ===== logic/swt_rr_arb.sv
`timescale 1ns/10ps
`include "swt_defs.svh"

module swt_rr_arb
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic i_sticky,
  input wire logic [3:0] i_req,
  input wire logic [3:0] i_credit_ok,
  input wire logic i_done,
  output logic [3:0] o_grant,
  output logic o_valid
);
  // ----------------------------------------------------------------
  // Port choice
  // ----------------------------------------------------------------
  logic [1:0] cur;
  wire logic [3:0] eligible;
  wire logic hold;
  wire logic [1:0] pick;
  wire logic pick_ok;

  // Next eligible port after the current one, round-robin
  function automatic logic [2:0] swt_next_port(input logic [3:0] elig,
                                                input logic [1:0] from);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int k = `SWT_NPORTS; k >= 1; k--)
    begin
      idx = from + 2'(k);
      if (elig[idx])
        res = {1'b1, idx};
    end
    return res;
  endfunction

  assign eligible = i_req & i_credit_ok;
  // Sticky keeps the port while it asks and is not done, credit or not
  // RL9 - stay on pending port
  // RL10 - leave port short of credit
  assign hold = o_valid && i_req[cur] && !i_done
                && (i_credit_ok[cur] || i_sticky);
  assign {pick_ok, pick} = swt_next_port(eligible, cur);

  // Grant register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur <= 2'h0;
      o_valid <= 1'b0;
      o_grant <= 4'h0;
    end
    else if (!hold)
    begin
      cur <= pick_ok ? pick : cur;
      o_valid <= pick_ok;
      o_grant <= pick_ok ? 4'(1) << pick : 4'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_ARB_STICKY: assert property ( // RL9
    i_sticky && o_valid && |(o_grant & i_req) && !i_done
    |=> o_valid && o_grant == $past(o_grant))
    else $error("sticky arbiter left a pending port");

  AST_ARB_CREDIT: assert property ( // RL10
    !i_sticky && o_valid && |(o_grant & i_req & ~i_credit_ok)
      && |(i_req & i_credit_ok & ~o_grant)
    |=> o_grant != $past(o_grant)
        && |(o_grant & $past(i_req) & $past(i_credit_ok)))
    else $error("arbiter stayed on port without credit");
endmodule // swt_rr_arb

// ===== logic/swt_tuning_regs.sv
// What this block does
// RL1 - Hold 12-bit user replay time-out, reset zero
// RL2 - Enable bit selects user replay time-out
// RL3 - Hold 14-bit user ack latency, reset zero
// RL4 - Enable bit selects user ack latency
// RL5 - Read-only flag shows VGA range decode
// RL6 - Mode bit picks store-forward or cut-through
// RL7 - Threshold applies slow port to fast port
// RL8 - Threshold code sets cycles before midpoint
// RL9 - Sticky arbitration stays on pending port
// RL10 - Otherwise arbiter moves to credited requester
// RL11 - Credit mode set releases all types together
// RL12 - Credit mode clear updates each type separately
// RL13 - Bit five orders packets across egress ports
// RL14 - Tag mode orders completions across tags
// RL15 - Serial bus or EEPROM may reload defaults
// RL16 - Disabled override uses internal value, next start
// RL17 - Reserved bits read zero, ignore writes
`timescale 1ns/10ps
`include "swt_defs.svh"

module swt_tuning_regs
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [7:0] I_CFG_ADDR,
  input wire logic [31:0] I_CFG_WDATA,
  input wire logic [3:0] I_CFG_BE,
  input wire logic I_CFG_WR,
  input wire logic I_CFG_RD,
  output logic [31:0] O_CFG_RDATA,
  output logic O_CFG_RVALID,
  input wire logic I_LOAD_WR,
  input wire logic [7:0] I_LOAD_ADDR,
  input wire logic [31:0] I_LOAD_DATA,
  input wire logic I_VGA_DECODE,
  input wire logic [11:0] I_REPLAY_DEFAULT,
  input wire logic I_REPLAY_START,
  output logic [11:0] O_REPLAY_LIMIT,
  input wire logic [13:0] I_ACK_DEFAULT,
  input wire logic I_ACK_START,
  output logic [13:0] O_ACK_LIMIT,
  output logic O_STORE_FORWARD,
  output logic O_CREDIT_ALL_TYPES,
  output logic O_EGRESS_ORDER,
  output logic O_TAG_ORDER,
  output logic [31:0] O_TEST_CONTROL,
  input wire logic I_PKT_START,
  input wire logic [11:0] I_PKT_LEN,
  input wire logic I_SLOW_TO_FAST,
  output logic [11:0] O_FWD_START,
  input wire logic [3:0] I_ARB_REQ,
  input wire logic [3:0] I_ARB_CREDIT_OK,
  input wire logic I_ARB_DONE,
  output logic [3:0] O_ARB_GRANT,
  output logic O_ARB_VALID
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  swt_pkg::swt_word_t test_b;
  swt_pkg::swt_word_t override_w;
  swt_pkg::swt_word_t mode_w;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte-lane merge restricted to writable bits
  function automatic logic [31:0] swt_merge(input logic [31:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be,
                                            input logic [31:0] wmask);
    logic [31:0] lanes;
    logic [31:0] m;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    m = lanes & wmask;
    return (old & ~m) | (wdata & m);
  endfunction

  // Next value of one register from both write sources
  function automatic logic [31:0] swt_next_reg(input logic [31:0] old,
                                               input logic cfg_hit,
                                               input logic load_hit,
                                               input logic [31:0] cdata,
                                               input logic [3:0] cbe,
                                               input logic [31:0] ldata,
                                               input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    if (cfg_hit)
      res = swt_merge(old, cdata, cbe, wmask);
    else if (load_hit)
      res = swt_merge(old, ldata, `SWT_ALL_BE, wmask);
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic cfg_test;
  wire logic cfg_ovr;
  wire logic cfg_mode;
  wire logic load_test;
  wire logic load_ovr;
  wire logic load_mode;

  // Software writes win over a concurrent default load
  assign cfg_test = I_CFG_WR && I_CFG_ADDR == `SWT_OFS_TEST_B;
  assign cfg_ovr = I_CFG_WR && I_CFG_ADDR == `SWT_OFS_OVERRIDE;
  assign cfg_mode = I_CFG_WR && I_CFG_ADDR == `SWT_OFS_MODE;
  // RL15 - default reload path
  assign load_test = I_LOAD_WR && I_LOAD_ADDR == `SWT_OFS_TEST_B;
  assign load_ovr = I_LOAD_WR && I_LOAD_ADDR == `SWT_OFS_OVERRIDE;
  assign load_mode = I_LOAD_WR && I_LOAD_ADDR == `SWT_OFS_MODE;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  wire logic [31:0] next_test_b;
  wire logic [31:0] next_override;
  wire logic [31:0] next_mode;

  // Masks keep reserved and read-only bits at zero
  // RL17 - reserved bits ignored
  assign next_test_b = swt_next_reg(test_b, cfg_test, load_test,
                                    I_CFG_WDATA, I_CFG_BE, I_LOAD_DATA,
                                    `SWT_WMASK_TEST_B);
  // RL1 - replay value written
  // RL3 - ack value written
  assign next_override = swt_next_reg(override_w, cfg_ovr, load_ovr,
                                      I_CFG_WDATA, I_CFG_BE, I_LOAD_DATA,
                                      `SWT_WMASK_OVERRIDE);
  assign next_mode = swt_next_reg(mode_w, cfg_mode, load_mode,
                                  I_CFG_WDATA, I_CFG_BE, I_LOAD_DATA,
                                  `SWT_WMASK_MODE);

  // Register file
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      test_b <= `SWT_RST_TEST_B;
      override_w <= `SWT_RST_OVERRIDE;
      mode_w <= `SWT_RST_MODE;
    end
    else
    begin
      test_b <= next_test_b;
      override_w <= next_override;
      mode_w <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire logic [31:0] override_view;
  wire logic [31:0] next_rdata;

  // VGA flag is live from the bridge decoder, never stored here
  // RL5 - read-only VGA flag
  assign override_view = {I_VGA_DECODE, override_w[30:0]};
  // Unmapped offsets read zero
  assign next_rdata =
    !I_CFG_RD ? `SWT_ZERO32 :
    (I_CFG_ADDR == `SWT_OFS_TEST_B) ? test_b :
    (I_CFG_ADDR == `SWT_OFS_OVERRIDE) ? override_view :
    (I_CFG_ADDR == `SWT_OFS_MODE) ? mode_w :
    `SWT_ZERO32;

  // Read answer one cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_CFG_RDATA <= `SWT_ZERO32;
      O_CFG_RVALID <= 1'b0;
    end
    else
    begin
      O_CFG_RDATA <= next_rdata;
      O_CFG_RVALID <= I_CFG_RD;
    end
  end

  // ----------------------------------------------------------------
  // Timer limits
  // ----------------------------------------------------------------
  wire logic replay_en;
  wire logic ack_en;
  wire logic [11:0] replay_user;
  wire logic [13:0] ack_user;
  wire logic [11:0] next_replay_limit;
  wire logic [13:0] next_ack_limit;

  assign replay_en = override_w[`SWT_REPLAY_EN];
  assign ack_en = override_w[`SWT_ACK_EN];
  assign replay_user = override_w[`SWT_REPLAY_MSB:`SWT_REPLAY_LSB];
  assign ack_user = override_w[`SWT_ACK_MSB:`SWT_ACK_LSB];
  // RL2 - user replay selected
  // RL16 - internal fallback
  assign next_replay_limit = replay_en ? replay_user : I_REPLAY_DEFAULT;
  // RL4 - user ack selected
  assign next_ack_limit = ack_en ? ack_user : I_ACK_DEFAULT;

  // Limits change only on a timer start, so a running timer never sees
  // its own limit move underneath it
  // RL16 - applied at next start
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_REPLAY_LIMIT <= 12'h000;
      O_ACK_LIMIT <= 14'h0000;
    end
    else
    begin
      if (I_REPLAY_START)
        O_REPLAY_LIMIT <= next_replay_limit;
      if (I_ACK_START)
        O_ACK_LIMIT <= next_ack_limit;
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs, straight from the mode flops, plus the test word from its own flops
  // ----------------------------------------------------------------
  // RL6 - store-forward select
  assign O_STORE_FORWARD = mode_w[`SWT_MODE_STORE_FWD];
  // RL11 - all types together
  // RL12 - per-type when clear
  assign O_CREDIT_ALL_TYPES = mode_w[`SWT_MODE_CREDIT_ALL];
  // RL13 - cross-port ordering
  assign O_EGRESS_ORDER = mode_w[`SWT_MODE_EGRESS_ORD];
  // RL14 - completion tag ordering
  assign O_TAG_ORDER = mode_w[`SWT_MODE_TAG_ORD];
  assign O_TEST_CONTROL = test_b;

  // ----------------------------------------------------------------
  // Forwarding threshold and port arbiter
  // ----------------------------------------------------------------
  swt_cut_thresh swt_cut_thresh_inst
  (
    .clk(I_CLK),
    .rst_b(I_RST_B),
    .i_start(I_PKT_START),
    .i_len(I_PKT_LEN),
    .i_slow_to_fast(I_SLOW_TO_FAST),
    .i_store_fwd(mode_w[`SWT_MODE_STORE_FWD]),
    .i_code(mode_w[`SWT_MODE_CT_MSB:`SWT_MODE_CT_LSB]),
    .o_fwd_start(O_FWD_START)
  );

  swt_rr_arb swt_rr_arb_inst
  (
    .clk(I_CLK),
    .rst_b(I_RST_B),
    .i_sticky(mode_w[`SWT_MODE_ARB_STICKY]),
    .i_req(I_ARB_REQ),
    .i_credit_ok(I_ARB_CREDIT_OK),
    .i_done(I_ARB_DONE),
    .o_grant(O_ARB_GRANT),
    .o_valid(O_ARB_VALID)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_ovr_write;
    I_CFG_WR && I_CFG_ADDR == `SWT_OFS_OVERRIDE && I_CFG_BE == 4'hF;
  endsequence

  sequence s_rd_ovr;
    I_CFG_RD && I_CFG_ADDR == `SWT_OFS_OVERRIDE;
  endsequence

  AST_REPLAY_STORE: assert property ( // RL1
    s_ovr_write
    |=> replay_user == $past(I_CFG_WDATA[`SWT_REPLAY_MSB:`SWT_REPLAY_LSB]))
    else $error("replay value not stored");

  AST_REPLAY_SELECT: assert property ( // RL2
    I_REPLAY_START && replay_en |=> O_REPLAY_LIMIT == $past(replay_user))
    else $error("user replay time-out not applied");

  AST_ACK_STORE: assert property ( // RL3
    s_ovr_write
    |=> ack_user == $past(I_CFG_WDATA[`SWT_ACK_MSB:`SWT_ACK_LSB]))
    else $error("ack latency not stored");

  AST_ACK_SELECT: assert property ( // RL4
    I_ACK_START && ack_en |=> O_ACK_LIMIT == $past(ack_user))
    else $error("user ack latency not applied");

  AST_VGA_FLAG: assert property ( // RL5
    s_rd_ovr |=> O_CFG_RDATA[31] == $past(I_VGA_DECODE))
    else $error("VGA flag misread");

  AST_FALLBACK: assert property ( // RL16
    I_REPLAY_START && !replay_en
    |=> O_REPLAY_LIMIT == $past(I_REPLAY_DEFAULT))
    else $error("replay fallback not used");

  AST_HOLD_LIMIT: assert property ( // RL16
    !I_ACK_START |=> $stable(O_ACK_LIMIT))
    else $error("ack limit moved without a timer start");

  AST_RESERVED: assert property ( // RL17
    s_rd_ovr |=> O_CFG_RDATA[15:13] == 3'h0 && mode_w[31:7] == 25'h0)
    else $error("reserved bits not zero");

  AST_LOAD: assert property ( // RL15
    I_LOAD_WR && !I_CFG_WR && I_LOAD_ADDR == `SWT_OFS_MODE
    |=> mode_w == ($past(I_LOAD_DATA) & `SWT_WMASK_MODE))
    else $error("default load lost");

  AST_CREDIT_MODE: assert property ( // RL11
    I_CFG_WR && I_CFG_ADDR == `SWT_OFS_MODE && I_CFG_BE[0]
    |=> O_CREDIT_ALL_TYPES == $past(I_CFG_WDATA[`SWT_MODE_CREDIT_ALL]))
    else $error("credit mode not taken from write");
endmodule // swt_tuning_regs

// ===== tb/swt_loader_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Default loader on the far side (serial bus or EEPROM)
// ------------------------------------------------------------
module swt_loader_model
(
  input wire logic i_clk,
  output logic o_load_wr,
  output logic [7:0] o_load_addr,
  output logic [31:0] o_load_data
);
  // Idle lines show no stale word
  initial
  begin
    o_load_wr = 1'b0;
    o_load_addr = 8'hFF;
    o_load_data = 32'h00000000;
  end

  task automatic load(input logic [7:0] addr, input logic [31:0] data);
    @(negedge i_clk);
    o_load_wr = 1'b1;
    o_load_addr = addr;
    o_load_data = data;
    @(negedge i_clk);
    o_load_wr = 1'b0;
    o_load_addr = ~addr; // Released: inverse, not last value
    o_load_data = ~data;
  endtask
endmodule // swt_loader_model

// ===== tb/swt_tuning_regs_test.sv
`timescale 1ns/10ps
`include "swt_defs.svh"

module swt_tuning_regs_test;
  logic I_CLK, I_RST_B, cfg_wr, cfg_rd, vga, rep_start, ack_start;
  logic pkt_start, s2f, arb_done, load_wr, rvalid, store_fwd;
  logic credit_all, egress_ord, tag_ord, arb_valid;
  logic [7:0] cfg_addr, load_addr;
  logic [3:0] cfg_be, arb_req, arb_credit, arb_grant;
  logic [11:0] pkt_len, fwd_start, rep_limit;
  logic [13:0] ack_limit;
  swt_pkg::swt_word_t cfg_wdata, rdata, load_data, test_ctl;
  int n_mismatch, n_checks;

  swt_tuning_regs swt_tuning_regs_inst (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_CFG_ADDR(cfg_addr), .I_CFG_WDATA(cfg_wdata), .I_CFG_BE(cfg_be),
    .I_CFG_WR(cfg_wr), .I_CFG_RD(cfg_rd), .O_CFG_RDATA(rdata),
    .O_CFG_RVALID(rvalid), .I_LOAD_WR(load_wr), .I_LOAD_ADDR(load_addr),
    .I_LOAD_DATA(load_data), .I_VGA_DECODE(vga),
    .I_REPLAY_DEFAULT(12'h555), .I_REPLAY_START(rep_start),
    .O_REPLAY_LIMIT(rep_limit), .I_ACK_DEFAULT(14'h2AAA),
    .I_ACK_START(ack_start), .O_ACK_LIMIT(ack_limit),
    .O_STORE_FORWARD(store_fwd), .O_CREDIT_ALL_TYPES(credit_all),
    .O_EGRESS_ORDER(egress_ord), .O_TAG_ORDER(tag_ord),
    .O_TEST_CONTROL(test_ctl), .I_PKT_START(pkt_start),
    .I_PKT_LEN(pkt_len), .I_SLOW_TO_FAST(s2f), .O_FWD_START(fwd_start),
    .I_ARB_REQ(arb_req), .I_ARB_CREDIT_OK(arb_credit),
    .I_ARB_DONE(arb_done), .O_ARB_GRANT(arb_grant),
    .O_ARB_VALID(arb_valid));

  swt_loader_model swt_loader_model_inst (.i_clk(I_CLK),
    .o_load_wr(load_wr), .o_load_addr(load_addr),
    .o_load_data(load_data));

  // ------------------------------------------------------------
  // Clock and helpers
  // ------------------------------------------------------------
  initial
  begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input swt_pkg::swt_word_t seen,
                       input swt_pkg::swt_word_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs move on the falling edge only
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(negedge I_CLK);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    cfg_wr = 1'b1;
    @(negedge I_CLK);
    cfg_wr = 1'b0;
  endtask

  // Read answer stands one cycle; a bounded wait guards a hang
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(negedge I_CLK);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge I_CLK);
    cfg_rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(negedge I_CLK);
      n++;
    end
    if (n == 4)
    begin
      n_mismatch++;
      $display("[ERR] read valid expected 1 seen %b", rvalid);
      conclude();
    end
    else
      check("read data", rdata, exp);
  endtask

  task automatic timers();
    @(negedge I_CLK);
    rep_start = 1'b1;
    ack_start = 1'b1;
    @(negedge I_CLK);
    rep_start = 1'b0;
    ack_start = 1'b0;
  endtask

  task automatic pkt(input logic [11:0] len, input logic sf,
                     input logic [11:0] exp);
    @(negedge I_CLK);
    pkt_start = 1'b1;
    pkt_len = len;
    s2f = sf;
    @(negedge I_CLK);
    pkt_start = 1'b0;
    check("forward start", {20'h00000, fwd_start}, {20'h00000, exp});
  endtask

  task automatic arb(input logic [3:0] req, input logic [3:0] cr,
                     input logic done, input logic [3:0] exp);
    @(negedge I_CLK);
    arb_req = req;
    arb_credit = cr;
    arb_done = done;
    @(negedge I_CLK);
    arb_done = 1'b0;
    check("grant", {27'h0, arb_valid, arb_grant}, {27'h0, |exp, exp});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {cfg_wr, cfg_rd, vga, rep_start, ack_start, pkt_start, s2f} = '0;
    {arb_done, cfg_addr, cfg_be, arb_req, arb_credit, pkt_len} = '0;
    cfg_wdata = 32'h00000000;
    I_RST_B = 1'b0;
    repeat (16) @(negedge I_CLK);
    I_RST_B = 1'b1;
    // Reset values and read-only flag
    check("test word", test_ctl, 32'h04000800);
    rd(`SWT_OFS_TEST_B, 32'h04000800);
    rd(`SWT_OFS_OVERRIDE, 32'h00000000);
    rd(`SWT_OFS_MODE, 32'h00000002);
    vga = 1'b1;
    rd(`SWT_OFS_OVERRIDE, 32'h80000000);
    // Byte lanes, reserved and read-only bits
    wr(`SWT_OFS_TEST_B, 32'hA5A55A5A, 4'hC);
    check("test word", test_ctl, 32'hA5A50800);
    wr(`SWT_OFS_OVERRIDE, 32'hFFFFFFFF, 4'hF);
    rd(`SWT_OFS_OVERRIDE, 32'hFFFF1FFF);
    wr(`SWT_OFS_OVERRIDE, 32'h00000000, 4'h1);
    vga = 1'b0;
    rd(`SWT_OFS_OVERRIDE, 32'h7FFF1F00);
    wr(8'h80, 32'hFFFFFFFF, 4'hF);
    rd(8'h80, 32'h00000000);
    wr(`SWT_OFS_MODE, 32'hFFFFFFFF, 4'hF);
    rd(`SWT_OFS_MODE, 32'h0000007F);
    // Timer overrides take effect at the next start only
    wr(`SWT_OFS_OVERRIDE, 32'h52341ABC, 4'hF);
    timers();
    check("replay", {20'h0, rep_limit}, 32'h00000ABC);
    check("ack", {18'h0, ack_limit}, 32'h00001234);
    wr(`SWT_OFS_OVERRIDE, 32'h02340ABC, 4'hF);
    check("replay", {20'h0, rep_limit}, 32'h00000ABC);
    timers();
    check("replay", {20'h0, rep_limit}, 32'h00000555);
    check("ack", {18'h0, ack_limit}, 32'h00002AAA);
    // Mode outputs, one bit at a time
    wr(`SWT_OFS_MODE, 32'h00000001, 4'hF);
    check("modes", {store_fwd, credit_all, egress_ord, tag_ord}, 4'h8);
    wr(`SWT_OFS_MODE, 32'h00000010, 4'hF);
    check("modes", {store_fwd, credit_all, egress_ord, tag_ord}, 4'h4);
    wr(`SWT_OFS_MODE, 32'h00000020, 4'hF);
    check("modes", {store_fwd, credit_all, egress_ord, tag_ord}, 4'h2);
    wr(`SWT_OFS_MODE, 32'h00000040, 4'hF);
    check("modes", {store_fwd, credit_all, egress_ord, tag_ord}, 4'h1);
    // Cut-through threshold for every code
    for (int c = 0; c < 4; c++)
    begin
      wr(`SWT_OFS_MODE, c << 1, 4'hF);
      pkt(12'd20, 1'b1, 12'd10 - c[11:0]);
    end
    pkt(12'd2, 1'b1, 12'd0);
    pkt(12'd20, 1'b0, 12'd10);
    wr(`SWT_OFS_MODE, 32'h00000007, 4'hF);
    pkt(12'd20, 1'b1, 12'd20);
    // Arbitration, plain then sticky
    wr(`SWT_OFS_MODE, 32'h00000000, 4'hF);
    arb(4'b0010, 4'b0010, 1'b0, 4'b0010);
    arb(4'b0110, 4'b0100, 1'b0, 4'b0100);
    wr(`SWT_OFS_MODE, 32'h00000008, 4'hF);
    arb(4'b0110, 4'b0010, 1'b0, 4'b0100);
    arb(4'b0110, 4'b0010, 1'b1, 4'b0010);
    arb(4'b0000, 4'b0000, 1'b0, 4'b0000);
    // Default reload, and a clash with a config write
    swt_loader_model_inst.load(`SWT_OFS_OVERRIDE, 32'hFFFFFFFF);
    rd(`SWT_OFS_OVERRIDE, 32'h7FFF1FFF);
    fork
      wr(`SWT_OFS_MODE, 32'h00000020, 4'hF);
      swt_loader_model_inst.load(`SWT_OFS_MODE, 32'h00000001);
    join
    rd(`SWT_OFS_MODE, 32'h00000020);
    // Lone load of the mode word, masked to its writable bits
    swt_loader_model_inst.load(`SWT_OFS_MODE, 32'hFFFFFFD1);
    rd(`SWT_OFS_MODE, 32'h00000051);
    check("modes", {store_fwd, credit_all, egress_ord, tag_ord}, 4'hD);
    conclude();
  end
endmodule // swt_tuning_regs_test
